/* File: ccr_cfg.svh */
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// Register offsets on the serial register port
`define CCR_ADDR_ILIM   8'h0F
`define CCR_ADDR_CTLA   8'h10
`define CCR_ADDR_CTLB   8'h11

// Defaults restored at reset and on a charger input edge
`define CCR_RST_ILIM    3'h0
`define CCR_RST_CTLA    8'h00
`define CCR_RST_CTLB    8'h00

// Readback padding above the current limit field, and the read data at reset and for unmapped addresses
`define CCR_ILIM_PAD    5'h00
`define CCR_RD_IDLE     8'h00

// Input current limit in mA: 50 90 150 200 300 400 450 1000
`define CCR_ILIM_0      11'h032
`define CCR_ILIM_1      11'h05A
`define CCR_ILIM_2      11'h096
`define CCR_ILIM_3      11'h0C8
`define CCR_ILIM_4      11'h12C
`define CCR_ILIM_5      11'h190
`define CCR_ILIM_6      11'h1C2
`define CCR_ILIM_7      11'h3E8

// Regulation voltage in mV: 4050 plus 50 per code, up to code 11
`define CCR_VREG_BASE   13'h0FD2
`define CCR_VREG_STEP   13'h0032
`define CCR_VREG_MAX    4'hB

// Recharge offsets below regulation in mV: 70 120 170 220
`define CCR_RCH_0       13'h0046
`define CCR_RCH_1       13'h0078
`define CCR_RCH_2       13'h00AA
`define CCR_RCH_3       13'h00DC

// Precharge rising threshold in mV: 2100 plus 150 per code
`define CCR_VPC_BASE    13'h0834
`define CCR_VPC_STEP    13'h0096

// Fractions of fast-charge current in percent: 5 10 20 30
`define CCR_PCT_0       5'h05
`define CCR_PCT_1       5'h0A
`define CCR_PCT_2       5'h14
`define CCR_PCT_3       5'h1E

// Edge option bits
`define CCR_OPT_RISE    0
`define CCR_OPT_FALL    1

// Arm pattern with all three stages filled, before edges are trusted
`define CCR_ARM_ALL     3'h7

`endif

/* File: ccr_evt_if.sv */
interface ccr_evt_if;
  logic restore;
  logic level;

  modport src (
    output restore,
    output level
  );

  modport dst (
    input restore,
    input level
  );
endinterface

/* File: ccr_input_edge.sv */
`include "ccr_cfg.svh"

module ccr_input_edge (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Charger input pin and edge option
  input  wire logic       charger_input_supply_i,
  input  wire logic [1:0] input_valid_reset_option_i,
  // Restore event toward the register bank
  ccr_evt_if.src          evt
);

  logic       sync1_q, sync1_d;
  logic       sync2_q, sync2_d;
  logic       prev_q,  prev_d;
  logic [2:0] arm_q,   arm_d;
  logic       restore_q, restore_d;
  logic       rise, fall;

  //////////////////////////////////////////////////////////////////////////
  // Sync, edge detect, option select

  always_comb begin
    sync1_d = charger_input_supply_i;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    // No edge until the pipe holds real samples, so reset is not an edge
    arm_d   = {arm_q[1:0], 1'b1};
    rise    = arm_q[2] && sync2_q && !prev_q;
    fall    = arm_q[2] && !sync2_q && prev_q;
    restore_d = (rise && input_valid_reset_option_i[`CCR_OPT_RISE]) ||
                (fall && input_valid_reset_option_i[`CCR_OPT_FALL]);
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      prev_q    <= 1'b0;
      arm_q     <= 3'h0;
      restore_q <= 1'b0;
    end else begin
      sync1_q   <= sync1_d;
      sync2_q   <= sync2_d;
      prev_q    <= prev_d;
      arm_q     <= arm_d;
      restore_q <= restore_d;
    end
  end

  assign evt.restore = restore_q;
  assign evt.level   = sync2_q;

  a_edge_restore: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    (arm_q == `CCR_ARM_ALL) && $rose(sync2_q) &&
    input_valid_reset_option_i[`CCR_OPT_RISE] |=> evt.restore)
    else $error("rising input edge did not restore defaults");

endmodule

/* File: ccr_pkg.sv */
package ccr_pkg;

  // First charger control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       force_precharge;
    logic [1:0] recharge_offset_sel;
    logic [3:0] battery_reg_voltage_sel;
    logic       charger_enable_bit;
  } ccr_ctla_s;

  // Second charger control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       battery_pulldown_en;
    logic [2:0] precharge_threshold_sel;
    logic [1:0] precharge_current_sel;
    logic [1:0] done_current_sel;
  } ccr_ctlb_s;

endpackage

/* File: charger_config_registers.sv */
`include "ccr_cfg.svh"

module charger_config_registers (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rd_ack_o,
  // Charger input and edge option
  input  wire logic        charger_input_supply_i,
  input  wire logic [1:0]  input_valid_reset_option_i,
  // Charger controls
  output logic             charger_en_o,
  output logic             force_precharge_o,
  output logic             battery_pulldown_en_o,
  output logic             defaults_restored_o,
  // Decoded settings
  output logic      [10:0] input_current_limit_ma_o,
  output logic      [12:0] reg_voltage_mv_o,
  output logic             reg_code_reserved_o,
  output logic      [12:0] recharge_mv_o,
  output logic      [12:0] precharge_threshold_mv_o,
  output logic      [4:0]  precharge_current_pct_o,
  output logic      [4:0]  done_current_pct_o
);

  ccr_evt_if evt_bus ();

  ccr_input_edge u_edge (
    .clock_i                    (clock_i),
    .rstn_i                     (rstn_i),
    .charger_input_supply_i     (charger_input_supply_i),
    .input_valid_reset_option_i (input_valid_reset_option_i),
    .evt                        (evt_bus.src)
  );

  //////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic [4:0] frac_pct(input logic [1:0] code);
    unique case (code)
      2'h0: frac_pct = `CCR_PCT_0;
      2'h1: frac_pct = `CCR_PCT_1;
      2'h2: frac_pct = `CCR_PCT_2;
      2'h3: frac_pct = `CCR_PCT_3;
    endcase
  endfunction

  function automatic logic [10:0] ilim_ma(input logic [2:0] code);
    unique case (code)
      3'h0: ilim_ma = `CCR_ILIM_0;
      3'h1: ilim_ma = `CCR_ILIM_1;
      3'h2: ilim_ma = `CCR_ILIM_2;
      3'h3: ilim_ma = `CCR_ILIM_3;
      3'h4: ilim_ma = `CCR_ILIM_4;
      3'h5: ilim_ma = `CCR_ILIM_5;
      3'h6: ilim_ma = `CCR_ILIM_6;
      3'h7: ilim_ma = `CCR_ILIM_7;
    endcase
  endfunction

  function automatic logic [12:0] rch_off(input logic [1:0] code);
    unique case (code)
      2'h0: rch_off = `CCR_RCH_0;
      2'h1: rch_off = `CCR_RCH_1;
      2'h2: rch_off = `CCR_RCH_2;
      2'h3: rch_off = `CCR_RCH_3;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [2:0]         ilim_q, ilim_d;
  ccr_pkg::ccr_ctla_s ctla_q, ctla_d;
  ccr_pkg::ccr_ctlb_s ctlb_q, ctlb_d;
  logic [7:0]         rdata_q, rdata_d;
  logic               rd_ack_q, rd_ack_d;

  always_comb begin
    ilim_d = ilim_q;
    ctla_d = ctla_q;
    ctlb_d = ctlb_q;
    // Edge restore beats a write in the same cycle: hardware event wins
    if (evt_bus.restore) begin
      ilim_d = `CCR_RST_ILIM;
      ctla_d = ccr_pkg::ccr_ctla_s'(`CCR_RST_CTLA);
      ctlb_d = ccr_pkg::ccr_ctlb_s'(`CCR_RST_CTLB);
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `CCR_ADDR_ILIM: ilim_d = reg_wdata_i[2:0];
        `CCR_ADDR_CTLA: ctla_d = ccr_pkg::ccr_ctla_s'(reg_wdata_i);
        `CCR_ADDR_CTLB: ctlb_d = ccr_pkg::ccr_ctlb_s'(reg_wdata_i);
        default: ;
      endcase
    end
    rd_ack_d = reg_rd_i;
    rdata_d  = rdata_q;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `CCR_ADDR_ILIM: rdata_d = {`CCR_ILIM_PAD, ilim_q};
        `CCR_ADDR_CTLA: rdata_d = ctla_q;
        `CCR_ADDR_CTLB: rdata_d = ctlb_q;
        default:        rdata_d = `CCR_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ilim_q   <= `CCR_RST_ILIM;
      ctla_q   <= ccr_pkg::ccr_ctla_s'(`CCR_RST_CTLA);
      ctlb_q   <= ccr_pkg::ccr_ctlb_s'(`CCR_RST_CTLB);
      rdata_q  <= `CCR_RD_IDLE;
      rd_ack_q <= 1'b0;
    end else begin
      ilim_q   <= ilim_d;
      ctla_q   <= ctla_d;
      ctlb_q   <= ctlb_d;
      rdata_q  <= rdata_d;
      rd_ack_q <= rd_ack_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rd_ack_o = rd_ack_q;

  //////////////////////////////////////////////////////////////////////////
  // Decoded outputs, registered so every output leaves a flop

  logic [10:0] ilim_ma_q,  ilim_ma_d;
  logic [12:0] vreg_q,     vreg_d;
  logic        resv_q,     resv_d;
  logic [12:0] rch_q,      rch_d;
  logic [12:0] vpc_q,      vpc_d;
  logic [4:0]  ipc_q,      ipc_d;
  logic [4:0]  done_q,     done_d;
  logic        en_q,       en_d;
  logic        frc_q,      frc_d;
  logic        pd_q,       pd_d;
  logic        restored_q, restored_d;

  always_comb begin
    ilim_ma_d = ilim_ma(ilim_q);
    resv_d    = ctla_q.battery_reg_voltage_sel > `CCR_VREG_MAX;
    // Reserved codes keep the last legal voltage rather than guess one
    vreg_d    = resv_d ? vreg_q :
                13'(`CCR_VREG_BASE +
                    `CCR_VREG_STEP * ctla_q.battery_reg_voltage_sel);
    rch_d     = 13'(vreg_d - rch_off(ctla_q.recharge_offset_sel));
    vpc_d     = 13'(`CCR_VPC_BASE +
                    `CCR_VPC_STEP * ctlb_q.precharge_threshold_sel);
    ipc_d     = frac_pct(ctlb_q.precharge_current_sel);
    done_d    = frac_pct(ctlb_q.done_current_sel);
    en_d      = ctla_q.charger_enable_bit;
    frc_d     = ctla_q.force_precharge &&
                ctla_q.charger_enable_bit;
    pd_d      = ctlb_q.battery_pulldown_en;
    restored_d = evt_bus.restore;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ilim_ma_q  <= `CCR_ILIM_0;
      vreg_q     <= `CCR_VREG_BASE;
      resv_q     <= 1'b0;
      rch_q      <= 13'(`CCR_VREG_BASE - `CCR_RCH_0);
      vpc_q      <= `CCR_VPC_BASE;
      ipc_q      <= `CCR_PCT_0;
      done_q     <= `CCR_PCT_0;
      en_q       <= 1'b0;
      frc_q      <= 1'b0;
      pd_q       <= 1'b0;
      restored_q <= 1'b0;
    end else begin
      ilim_ma_q  <= ilim_ma_d;
      vreg_q     <= vreg_d;
      resv_q     <= resv_d;
      rch_q      <= rch_d;
      vpc_q      <= vpc_d;
      ipc_q      <= ipc_d;
      done_q     <= done_d;
      en_q       <= en_d;
      frc_q      <= frc_d;
      pd_q       <= pd_d;
      restored_q <= restored_d;
    end
  end

  assign input_current_limit_ma_o = ilim_ma_q;
  assign reg_voltage_mv_o         = vreg_q;
  assign reg_code_reserved_o      = resv_q;
  assign recharge_mv_o            = rch_q;
  assign precharge_threshold_mv_o = vpc_q;
  assign precharge_current_pct_o  = ipc_q;
  assign done_current_pct_o       = done_q;
  assign charger_en_o             = en_q;
  assign force_precharge_o        = frc_q;
  assign battery_pulldown_en_o    = pd_q;
  assign defaults_restored_o      = restored_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  a_ilim_top_code: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    reg_wr_i && !evt_bus.restore && reg_addr_i == `CCR_ADDR_ILIM &&
    reg_wdata_i[2:0] == 3'h7 |=> ##1 input_current_limit_ma_o == 11'h3E8)
    else $error("current limit code 7 not 1000 mA");

  // Restored flag is registered alongside the fields, so both show together
  a_restore_defaults: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    evt_bus.restore |=> ilim_q == `CCR_RST_ILIM &&
    ctla_q == `CCR_RST_CTLA && ctlb_q == `CCR_RST_CTLB &&
    defaults_restored_o)
    else $error("fields not restored after input edge");

  a_restore_edge: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    evt_bus.restore |->
    $past(evt_bus.level) != $past(evt_bus.level, 2) &&
    ($past(evt_bus.level) ? $past(input_valid_reset_option_i[`CCR_OPT_RISE])
                          : $past(input_valid_reset_option_i[`CCR_OPT_FALL])))
    else $error("restore without an enabled input edge");

  a_force_gated: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    force_precharge_o |-> charger_en_o && $past(ctla_q.force_precharge))
    else $error("forced precharge while charger disabled");

  a_recharge_max: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(ctla_q.recharge_offset_sel) == 2'h3 |->
    recharge_mv_o == 13'(reg_voltage_mv_o - 13'h00DC))
    else $error("recharge offset code 3 not 220 mV below");

  a_vreg_base: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    reg_wr_i && !evt_bus.restore && reg_addr_i == `CCR_ADDR_CTLA &&
    reg_wdata_i[4:1] == 4'h0 |=> ##1
    reg_voltage_mv_o == 13'h0FD2 && !reg_code_reserved_o)
    else $error("regulation code 0 not 4050 mV");

  a_vreg_reserved: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    reg_code_reserved_o |-> $stable(reg_voltage_mv_o))
    else $error("reserved regulation code changed voltage");

  a_enable_follow: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    reg_wr_i && !evt_bus.restore && reg_addr_i == `CCR_ADDR_CTLA |=>
    ##1 charger_en_o == $past(reg_wdata_i[0], 2))
    else $error("charger enable did not follow write");

  a_pulldown_follow: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    reg_wr_i && !evt_bus.restore && reg_addr_i == `CCR_ADDR_CTLB |=>
    ##1 battery_pulldown_en_o == $past(reg_wdata_i[7], 2))
    else $error("pulldown enable did not follow write");

  a_vpc_top: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    reg_wr_i && !evt_bus.restore && reg_addr_i == `CCR_ADDR_CTLB &&
    reg_wdata_i[6:4] == 3'h7 |=> ##1 precharge_threshold_mv_o == 13'h0C4E)
    else $error("precharge threshold code 7 not 3150 mV");

  a_ipc_top: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(ctlb_q.precharge_current_sel) == 2'h3 |->
    precharge_current_pct_o == 5'h1E)
    else $error("precharge current code 3 not 30 percent");

  a_done_low: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(ctlb_q.done_current_sel) == 2'h0 |->
    done_current_pct_o == 5'h05)
    else $error("done threshold code 0 not 5 percent");

endmodule

/* File: charger_config_registers_tb.sv */
`include "ccr_cfg.svh"

module charger_config_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    int          sel;
    logic [12:0] exp;
  } ccr_tb_note_s;

  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        supply_i = 1'b0;
  logic [1:0]  option_i = 2'h0;
  logic        probe = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        reg_rd_ack_o;
  logic        charger_en_o;
  logic        force_precharge_o;
  logic        battery_pulldown_en_o;
  logic        defaults_restored_o;
  logic [10:0] input_current_limit_ma_o;
  logic [12:0] reg_voltage_mv_o;
  logic        reg_code_reserved_o;
  logic [12:0] recharge_mv_o;
  logic [12:0] precharge_threshold_mv_o;
  logic [4:0]  precharge_current_pct_o;
  logic [4:0]  done_current_pct_o;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  logic [15:0] s = 16'h8493;
  ccr_tb_note_s notes[$];
  string       names[9] = '{"rdata", "ilim", "vreg", "recharge", "vpc",
                            "pc_pct", "done_pct", "flags", "pulldown"};
  logic [10:0] ilim[8] = '{11'h032, 11'h05A, 11'h096, 11'h0C8,
                           11'h12C, 11'h190, 11'h1C2, 11'h3E8};
  logic [12:0] rch[4] = '{13'h0046, 13'h0078, 13'h00AA, 13'h00DC};
  logic [12:0] pct[4] = '{13'h0005, 13'h000A, 13'h0014, 13'h001E};

  charger_config_registers charger_config_registers_inst (
    .clock_i                    (clock_i),
    .rstn_i                     (rstn_i),
    .reg_wr_i                   (reg_wr_i),
    .reg_rd_i                   (reg_rd_i),
    .reg_addr_i                 (reg_addr_i),
    .reg_wdata_i                (reg_wdata_i),
    .reg_rdata_o                (reg_rdata_o),
    .reg_rd_ack_o               (reg_rd_ack_o),
    .charger_input_supply_i     (supply_i),
    .input_valid_reset_option_i (option_i),
    .charger_en_o               (charger_en_o),
    .force_precharge_o          (force_precharge_o),
    .battery_pulldown_en_o      (battery_pulldown_en_o),
    .defaults_restored_o        (defaults_restored_o),
    .input_current_limit_ma_o   (input_current_limit_ma_o),
    .reg_voltage_mv_o           (reg_voltage_mv_o),
    .reg_code_reserved_o        (reg_code_reserved_o),
    .recharge_mv_o              (recharge_mv_o),
    .precharge_threshold_mv_o   (precharge_threshold_mv_o),
    .precharge_current_pct_o    (precharge_current_pct_o),
    .done_current_pct_o         (done_current_pct_o)
  );

  initial begin
    forever #2 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [15:0] lfsr(logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [12:0] seen(int sel);
    case (sel)
      0: seen = {5'h00, reg_rdata_o};
      1: seen = {2'h0, input_current_limit_ma_o};
      2: seen = reg_voltage_mv_o;
      3: seen = recharge_mv_o;
      4: seen = precharge_threshold_mv_o;
      5: seen = {8'h00, precharge_current_pct_o};
      6: seen = {8'h00, done_current_pct_o};
      7: seen = {10'h000, reg_code_reserved_o, force_precharge_o,
                 charger_en_o};
      default: seen = {12'h000, battery_pulldown_en_o};
    endcase
  endfunction

  task automatic conclude();
    if (notes.size() != 0) error_cnt++;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic take();
    ccr_tb_note_s n;
    compares++;
    if (notes.size() == 0) begin
      error_cnt++;
      $display("BAD result with no note");
    end else begin
      n = notes.pop_front();
      if (seen(n.sel) !== n.exp) begin
        error_cnt++;
        $display("BAD %s exp %h got %h", names[n.sel], n.exp, seen(n.sel));
      end
    end
  endtask

  // Results are settled by the falling edge
  always @(negedge clock_i) begin
    if (reg_rd_ack_o === 1'b1) take();
    if (probe === 1'b1) begin
      while (notes.size() > 0 && notes[0].sel != 0) take();
    end
  end

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  task automatic note(int sel, logic [12:0] e);
    notes.push_back('{sel, e});
  endtask

  task automatic flush();
    @(posedge clock_i);
    probe <= 1'b1;
    @(posedge clock_i);
    probe <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    note(0, {5'h00, e});
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic defaults_check();
    rd(`CCR_ADDR_ILIM, 8'h00);
    rd(`CCR_ADDR_CTLA, 8'h00);
    rd(`CCR_ADDR_CTLB, 8'h00);
    note(1, 13'h0032);
    note(2, 13'h0FD2);
    note(3, 13'h0F8C);
    note(4, 13'h0834);
    note(5, 13'h0005);
    note(6, 13'h0005);
    note(7, 13'h0000);
    note(8, 13'h0000);
    flush();
  endtask

  // Six option and edge pairs; only enabled directions restore
  task automatic restore_case(logic [1:0] opt, logic lvl, logic want);
    bit got;
    got = 1'b0;
    @(posedge clock_i);
    option_i <= opt;
    wr(`CCR_ADDR_ILIM, 8'h07);
    wr(`CCR_ADDR_CTLA, 8'h7F);
    wr(`CCR_ADDR_CTLB, 8'hFF);
    @(posedge clock_i);
    supply_i <= lvl;
    for (int n = 0; n < 12; n++) begin
      @(posedge clock_i);
      #1;
      if (defaults_restored_o === 1'b1) got = 1'b1;
    end
    compares++;
    if (got !== want) begin
      error_cnt++;
      $display("BAD restored exp %b got %b", want, got);
    end
    rd(`CCR_ADDR_ILIM, want ? 8'h00 : 8'h07);
    rd(`CCR_ADDR_CTLA, want ? 8'h00 : 8'h7F);
    rd(`CCR_ADDR_CTLB, want ? 8'h00 : 8'hFF);
  endtask

  ////////////////////////////////////////////////////////////////////////////

  initial begin
    logic [7:0]  d;
    logic [12:0] v;
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    defaults_check();
    s = lfsr(s);
    wr(8'h12, s[7:0]);
    rd(8'h12, 8'h00);
    $display("test defaults done");
    // Upper bits of the limit register are not stored
    for (int c = 0; c < 8; c++) begin
      s = lfsr(s);
      wr(`CCR_ADDR_ILIM, {s[4:0], 3'(c)});
      rd(`CCR_ADDR_ILIM, {5'h00, 3'(c)});
      note(1, {2'h0, ilim[c]});
      flush();
    end
    $display("test current limit done");
    v = 13'h0FD2;
    for (int c = 0; c < 16; c++) begin
      s = lfsr(s);
      d = {s[1], 2'(c), 4'(c), s[0]};
      if (c < 12) v = 13'h0FD2 + 13'h0032 * 13'(c);
      wr(`CCR_ADDR_CTLA, d);
      rd(`CCR_ADDR_CTLA, d);
      note(2, v);
      note(3, v - rch[c % 4]);
      note(7, {10'h000, c > 11, s[1] & s[0], s[0]});
      flush();
    end
    $display("test control a done");
    for (int c = 0; c < 8; c++) begin
      s = lfsr(s);
      d = {s[0], 3'(c), 2'(c), 2'(c + 1)};
      wr(`CCR_ADDR_CTLB, d);
      rd(`CCR_ADDR_CTLB, d);
      note(4, 13'h0834 + 13'h0096 * 13'(c));
      note(5, pct[c % 4]);
      note(6, pct[(c + 1) % 4]);
      note(8, {12'h000, s[0]});
      flush();
    end
    $display("test control b done");
    restore_case(2'h1, 1'b1, 1'b1);
    note(2, 13'h0FD2);
    note(1, 13'h0032);
    flush();
    restore_case(2'h1, 1'b0, 1'b0);
    restore_case(2'h2, 1'b1, 1'b0);
    restore_case(2'h2, 1'b0, 1'b1);
    restore_case(2'h3, 1'b1, 1'b1);
    restore_case(2'h0, 1'b0, 1'b0);
    $display("test input edge done");
    // Second reset in mid-run with fields set
    @(posedge clock_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    defaults_check();
    $display("test second reset done");
    conclude();
  end
endmodule
